// >>> intpin_consts.svh
// constants for the interrupt pin configuration block
// assumes a wishbone classic slave with 32-bit data and byte addresses
`ifndef INTPIN_CONSTS_SVH
`define INTPIN_CONSTS_SVH
`define ADDR_PIN_CONFIG 8'h18
`define ADDR_ROUTE_ONE 8'h20
`define ADDR_ROUTE_TWO 8'h24
`define ADDR_SYS_STATUS 8'h28
`define ADDR_IRQ_STATUS 8'h2c
`define ADDR_IRQ_MASK 8'h30
`define ADDR_CONTROL 8'h34
`define BIT_TRIG_MODE 7
`define BIT_DRDY_PULSE 3
`define BIT_PIN_FUNC 2
`define BIT_DRIVER 1
`define BIT_POLARITY 0
`define PIN_CONFIG_RESET 8'h01
`define PIN_CONFIG_KEEP 8'h03
`define DRDY_PULSE_NS 32000
`define CLK_PERIOD_NS 10
`define DRDY_PULSE_CYCLES (`DRDY_PULSE_NS / `CLK_PERIOD_NS)
`endif

// >>> intpin_pkg.sv
// types for the interrupt pin configuration block
// assumes intpin_consts.svh supplies the numbers
package intpin_pkg;
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;
  typedef enum logic [1:0] {
    TRIG_IDLE = 2'b00,
    TRIG_SINGLE = 2'b01,
    TRIG_FULL = 2'b10
  } trig_state_t;
endpackage

// >>> intpin_cfg.sv
// interrupt pin driver and external trigger logic with wishbone registers
// assumes pins are resolved outside from o/oe; trigger and strap are async pins
`timescale 1ns/100ps
`default_nettype none
`include "intpin_consts.svh"

// How it works
// - pin-function 0 makes the second pin an interrupt output with routing.
// - pin-function 1: rising pin edge triggers full or single acquisition.
// - system status shows trigger enabled when pin-function selects it and no motion-detect strap.
// - trigger enabled ignores second-pin routing and floats the pin.
// - motion-detect strap ignores pin-function; no trigger then.
// - driver bit 0 push-pull, 1 open-drain or open-source.
// - driver bit survives soft reset; cleared only by power-up or hibernate.
// - motion-detect strap forces open-drain, ignoring the driver bit.
// - polarity 0 means active low, idle high, negative data-ready pulse.
// - polarity 1, the default, means active high, positive pulses.
// - polarity bit survives soft reset; set back to 1 only by power-up or hibernate.
// - motion-detect strap forces active low on both outputs.
// - open-drain drives 0 or floats; open-source drives 1 or floats.
// - pulse mode emits 32 us data-ready pulse per output cycle, ORed.
module intpin_cfg
  import intpin_pkg::*;
#(
  parameter int EVENT_W = 8,
  parameter int PULSE_CYCLES = `DRDY_PULSE_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic hibernate_i,
  input wire logic soft_reset_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // events from the sensor core
  input wire logic [EVENT_W-1:0] event_flags_i,
  input wire logic data_ready_event_i,
  input wire logic odr_tick_i,
  input wire logic boot_config_strap_i,
  // pins
  output logic interrupt_pin_one_o,
  output logic interrupt_pin_one_oe_o,
  input wire logic interrupt_pin_two_i,
  output logic interrupt_pin_two_o,
  output logic interrupt_pin_two_oe_o,
  // acquisition requests and status interrupt
  output logic acq_single_o,
  output logic acq_full_o,
  output logic irq_o
);
  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

  logic [7:0] pin_config_r;
  logic [EVENT_W-1:0] route_one_r, route_two_r;
  logic [1:0] irq_status_r, irq_mask_r;
  logic [2:0] trig_sync_r;
  logic [1:0] strap_sync_r;
  logic [CNT_W-1:0] pulse_cnt_r;
  trig_state_t trig_state_r, trig_state_nxt;
  logic ack_r;
  logic [31:0] rdata_r;

  // register decode
  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire rd = req && !wb_we_i;
  wire wr_cfg = wr && (wb_adr_i == `ADDR_PIN_CONFIG);
  wire wr_r1 = wr && (wb_adr_i == `ADDR_ROUTE_ONE);
  wire wr_r2 = wr && (wb_adr_i == `ADDR_ROUTE_TWO);
  wire wr_mask = wr && (wb_adr_i == `ADDR_IRQ_MASK);
  wire rd_stat = rd && (wb_adr_i == `ADDR_IRQ_STATUS);

  // strap effects
  wire motion_mode = strap_sync_r[1];
  wire trig_enabled = pin_config_r[`BIT_PIN_FUNC] && !motion_mode;
  wire open_drv = motion_mode || pin_config_r[`BIT_DRIVER];
  wire active_high = !motion_mode && pin_config_r[`BIT_POLARITY];

  wire pulse_mode = pin_config_r[`BIT_DRDY_PULSE] && !motion_mode;
  wire pulse_on = pulse_cnt_r != '0;
  wire drdy_src = pulse_mode ? pulse_on : data_ready_event_i;

  wire assert_one = |(route_one_r & event_flags_i) || drdy_src;
  wire assert_two = !trig_enabled && (|(route_two_r & event_flags_i));

  function automatic pin_drive_t drive(input logic act, input logic hi, input logic od);
    pin_drive_t d;
    d.o = act ~^ hi;
    d.oe = od ? act : 1'b1;
    return d;
  endfunction

  pin_drive_t d1, d2;
  assign d1 = drive(assert_one, active_high, open_drv);
  assign d2 = drive(assert_two, active_high, open_drv);
  assign interrupt_pin_one_o = d1.o;
  assign interrupt_pin_one_oe_o = d1.oe;
  assign interrupt_pin_two_o = d2.o;
  assign interrupt_pin_two_oe_o = trig_enabled ? 1'b0 : d2.oe;

  // rising edge of trigger, read from synced stages only
  wire trig_rise = trig_enabled && trig_sync_r[1] && !trig_sync_r[2];

  always_comb begin
    trig_state_nxt = TRIG_IDLE;
    unique case (trig_state_r)
      TRIG_IDLE: begin
        if (trig_rise) begin
          trig_state_nxt = pin_config_r[`BIT_TRIG_MODE] ? TRIG_FULL : TRIG_SINGLE;
        end
      end
      TRIG_SINGLE, TRIG_FULL: begin
        trig_state_nxt = TRIG_IDLE;
      end
      default: begin
        // code 2'b11 is never entered; recover to idle rather than stick
        trig_state_nxt = TRIG_IDLE;
      end
    endcase
  end
  assign acq_single_o = trig_state_r == TRIG_SINGLE;
  assign acq_full_o = trig_state_r == TRIG_FULL;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      trig_sync_r <= 3'h0;
      strap_sync_r <= 2'h0;
      trig_state_r <= TRIG_IDLE;
    end else begin
      trig_sync_r <= {trig_sync_r[1:0], interrupt_pin_two_i};
      strap_sync_r <= {strap_sync_r[0], boot_config_strap_i};
      trig_state_r <= trig_state_nxt;
    end
  end

  // soft reset keeps driver and polarity
  always_ff @(posedge core_clk_i) begin
    if (reset_i || hibernate_i) begin
      pin_config_r <= `PIN_CONFIG_RESET;
    end else if (wr_cfg) begin
      pin_config_r <= wb_dat_i[7:0];
    end else if (soft_reset_i) begin
      pin_config_r <= (pin_config_r & `PIN_CONFIG_KEEP) | (`PIN_CONFIG_RESET & ~`PIN_CONFIG_KEEP);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i || hibernate_i || soft_reset_i) begin
      route_one_r <= '0;
      route_two_r <= '0;
      irq_mask_r <= 2'h0;
    end else begin
      if (wr_r1) route_one_r <= wb_dat_i[EVENT_W-1:0];
      if (wr_r2) route_two_r <= wb_dat_i[EVENT_W-1:0];
      if (wr_mask) irq_mask_r <= wb_dat_i[1:0];
    end
  end

  // status: bit0 trigger seen, bit1 data ready; set wins over read clear
  wire [1:0] irq_set = {data_ready_event_i, trig_rise};
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_status_r <= 2'h0;
    end else begin
      irq_status_r <= (rd_stat ? 2'h0 : irq_status_r) | irq_set;
    end
  end
  assign irq_o = |(irq_status_r & irq_mask_r);

  always_ff @(posedge core_clk_i) begin
    if (reset_i || !pulse_mode) begin
      pulse_cnt_r <= '0;
    end else if (odr_tick_i) begin
      pulse_cnt_r <= CNT_W'(PULSE_CYCLES);
    end else if (pulse_on) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  wire [31:0] rmux =
    (wb_adr_i == `ADDR_PIN_CONFIG) ? {24'h0, pin_config_r} :
    (wb_adr_i == `ADDR_ROUTE_ONE) ? 32'(route_one_r) :
    (wb_adr_i == `ADDR_ROUTE_TWO) ? 32'(route_two_r) :
    (wb_adr_i == `ADDR_SYS_STATUS) ? {30'h0, motion_mode, trig_enabled} :
    (wb_adr_i == `ADDR_IRQ_STATUS) ? {30'h0, irq_status_r} :
    (wb_adr_i == `ADDR_IRQ_MASK) ? {30'h0, irq_mask_r} : 32'h0;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= req;
      if (rd) rdata_r <= rmux;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  AST_SYS_STATUS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    trig_enabled == (pin_config_r[`BIT_PIN_FUNC] && !strap_sync_r[1]))
    else $error("trigger status wrong");

  AST_PIN_FLOAT: assert property (@(posedge core_clk_i) disable iff (reset_i)
    trig_enabled |-> !interrupt_pin_two_oe_o)
    else $error("pin two driven");

  AST_TRIG_ACQ: assert property (@(posedge core_clk_i) disable iff (reset_i)
    trig_rise |=> (acq_single_o ^ acq_full_o) ##1 !(acq_single_o || acq_full_o))
    else $error("trigger request wrong");

  AST_STRAP_LOW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (motion_mode && interrupt_pin_one_oe_o) |-> !interrupt_pin_one_o)
    else $error("strap not active low");

  AST_OPEN_DRV: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (open_drv && interrupt_pin_one_oe_o) |-> interrupt_pin_one_o == active_high)
    else $error("open driver level");

  AST_PUSH_PULL: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !open_drv |-> interrupt_pin_one_oe_o)
    else $error("push-pull floated");

  AST_KEEP_CFG: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (soft_reset_i && !wr_cfg && !hibernate_i) |=>
    pin_config_r[1:0] == $past(pin_config_r[1:0])) else $error("config lost");

  AST_PULSE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (pulse_mode && odr_tick_i) |=> pulse_cnt_r == CNT_W'(PULSE_CYCLES))
    else $error("pulse not started");

  // ack lasts exactly one cycle
  AST_ACK_PULSE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  // a new request is answered on the next edge
  AST_ACK_ANSWER: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acked");

  AST_PP_HIGH: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!open_drv && active_high) |-> (interrupt_pin_one_o == assert_one))
    else $error("active high level wrong");

  AST_PP_LOW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!open_drv && !active_high) |-> (interrupt_pin_one_o == !assert_one))
    else $error("active low level wrong");

  AST_OD_IDLE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (open_drv && !assert_one) |-> !interrupt_pin_one_oe_o)
    else $error("open driver not floating");

  AST_OD_ACTIVE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (open_drv && assert_one) |-> interrupt_pin_one_oe_o)
    else $error("open driver not driving");

  AST_TWO_OUTPUT: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!trig_enabled && !open_drv) |-> interrupt_pin_two_oe_o)
    else $error("pin two not driven");

  AST_ROUTE_IGNORED: assert property (@(posedge core_clk_i) disable iff (reset_i)
    trig_enabled |-> !assert_two)
    else $error("routing reached pin two");

  AST_STRAP_NO_TRIG: assert property (@(posedge core_clk_i) disable iff (reset_i)
    motion_mode |-> !trig_enabled)
    else $error("trigger in motion mode");

  AST_STRAP_OD: assert property (@(posedge core_clk_i) disable iff (reset_i)
    motion_mode |-> open_drv)
    else $error("strap not open drain");

  AST_STRAP_TWO_LOW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (motion_mode && interrupt_pin_two_oe_o) |-> !interrupt_pin_two_o)
    else $error("pin two not active low");

  AST_HIB_CLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
    hibernate_i |=> (pin_config_r == `PIN_CONFIG_RESET))
    else $error("hibernate kept config");

  AST_KEEP_POL: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (soft_reset_i && !wr_cfg && !hibernate_i) |=>
    pin_config_r[`BIT_POLARITY] == $past(pin_config_r[`BIT_POLARITY])) else $error("pol lost");

  AST_SOFT_DEFAULTS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (soft_reset_i && !wr_cfg && !hibernate_i) |=> (pin_config_r[7:2] == 6'h00))
    else $error("soft reset kept upper bits");

  AST_TRIG_FULL: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (trig_rise && pin_config_r[`BIT_TRIG_MODE]) |=> acq_full_o)
    else $error("full run missing");

  AST_TRIG_SINGLE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (trig_rise && !pin_config_r[`BIT_TRIG_MODE]) |=> acq_single_o)
    else $error("single run missing");

  AST_NO_SPURIOUS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !trig_rise |=> !(acq_single_o || acq_full_o))
    else $error("request without edge");

  // read clears status when nothing new arrives
  AST_READ_CLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (rd_stat && !data_ready_event_i && !trig_rise) |=> (irq_status_r == 2'h0))
    else $error("status not cleared");

  AST_PULSE_END: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (pulse_mode && pulse_cnt_r == CNT_W'(1) && !odr_tick_i) |=> !pulse_on)
    else $error("pulse too long");

  AST_PULSE_PIN: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (pulse_mode && pulse_on) |-> assert_one)
    else $error("pulse not on pin");
endmodule
`default_nettype wire

// >>> host_model.sv
// host side of the second pin: drives the trigger, resolves the wire
// assumes a pull-up on the pin when nobody drives it
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // pin
  input wire logic core_clk_i,
  input wire logic pin_o_i,
  input wire logic pin_oe_i,
  output logic pin_lvl_o
);
  logic drv_r = 1'b0;
  logic trig_r = 1'b0;
  // pull-up wins only while both sides float
  assign pin_lvl_o = pin_oe_i ? pin_o_i : (drv_r ? trig_r : 1'b1);
  task automatic fire();
    @(posedge core_clk_i);
    drv_r <= 1'b1;
    trig_r <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    trig_r <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    drv_r <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the interrupt pin block
// assumes route bit 0 selects event flag 0 for a pin
`timescale 1ns/100ps
`default_nettype none
module tb;
  import intpin_pkg::*;
  logic core_clk_i = 1'b0, reset_i = 1'b1, hib = 1'b0, srst = 1'b0, strap = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic drdy = 1'b0, tick = 1'b0;
  logic [7:0] adr = 8'h00, ev = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, p1, p1e, p2i, p2, p2e, a_s, a_f, irq;
  int mismatches = 0, n_checks = 0, cycles = 0, ns = 0, nf = 0;
  always #5 core_clk_i = ~core_clk_i;
  intpin_cfg #(.EVENT_W(8), .PULSE_CYCLES(8)) i_intpin_cfg (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .hibernate_i(hib), .soft_reset_i(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .event_flags_i(ev), .data_ready_event_i(drdy),
    .odr_tick_i(tick), .boot_config_strap_i(strap), .interrupt_pin_one_o(p1),
    .interrupt_pin_one_oe_o(p1e), .interrupt_pin_two_i(p2i), .interrupt_pin_two_o(p2),
    .interrupt_pin_two_oe_o(p2e), .acq_single_o(a_s), .acq_full_o(a_f), .irq_o(irq));
  host_model i_host_model (.core_clk_i(core_clk_i), .pin_o_i(p2), .pin_oe_i(p2e),
    .pin_lvl_o(p2i));
  always @(posedge core_clk_i) begin
    cycles++;
    ns += (a_s === 1'b1);
    nf += (a_f === 1'b1);
    if (cycles > 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic trig(input logic [7:0] cfg);
    bus(1'b1, 8'h18, {24'h0, cfg});
    ns = 0;
    nf = 0;
    i_host_model.fire();
    settle();
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    bus(1'b0, 8'h18, 32'h0);
    chk("cfg reset", q, 32'h1);
    settle();
    chk("idle high pp", {p1e, p1}, 2'b10);
    bus(1'b1, 8'h18, 32'h0);
    settle();
    chk("idle low pol", {p1e, p1}, 2'b11);
    bus(1'b1, 8'h20, 32'h1);
    ev <= 8'h01;
    settle();
    chk("assert low", {p1e, p1}, 2'b10);
    bus(1'b1, 8'h18, 32'h2);
    settle();
    chk("od asserted", {p1e, p1}, 2'b10);
    @(posedge core_clk_i);
    ev <= 8'h00;
    settle();
    chk("od float", p1e, 1'b0);
    bus(1'b1, 8'h18, 32'h3);
    @(posedge core_clk_i);
    srst <= 1'b1;
    @(posedge core_clk_i);
    srst <= 1'b0;
    bus(1'b0, 8'h18, 32'h0);
    chk("kept bits", q[1:0], 2'b11);
    bus(1'b1, 8'h24, 32'h1);
    ev <= 8'h01;
    trig(8'h04);
    chk("pin two input", p2e, 1'b0);
    chk("single acq", {ns[1:0], nf[1:0]}, 4'b0100);
    chk("masked irq", irq, 1'b0);
    bus(1'b0, 8'h28, 32'h0);
    chk("trig shown", q[1:0], 2'b01);
    bus(1'b0, 8'h2c, 32'h0);
    bus(1'b1, 8'h30, 32'h1);
    trig(8'h85);
    chk("full acq", {ns[1:0], nf[1:0]}, 4'b0001);
    chk("irq on", irq, 1'b1);
    bus(1'b0, 8'h2c, 32'h0);
    chk("status bit", q[0], 1'b1);
    @(negedge core_clk_i);
    chk("irq cleared", irq, 1'b0);
    bus(1'b1, 8'h18, 32'h9);
    @(posedge core_clk_i);
    tick <= 1'b1;
    drdy <= 1'b1;
    @(posedge core_clk_i);
    tick <= 1'b0;
    drdy <= 1'b0;
    @(negedge core_clk_i);
    chk("pulse on", {p1e, p1}, 2'b11);
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("pulse off", {p1e, p1}, 2'b10);
    bus(1'b0, 8'h2c, 32'h0);
    chk("drdy status", q[1:0], 2'b10);
    @(posedge core_clk_i);
    strap <= 1'b1;
    trig(8'h85);
    chk("no trig", {ns[1:0], nf[1:0]}, 4'b0000);
    chk("pin two od low", {p2e, p2}, 2'b10);
    bus(1'b0, 8'h28, 32'h0);
    chk("motion shown", q[1:0], 2'b10);
    ev <= 8'h00;
    settle();
    chk("od released", {p1e, p2e}, 2'b00);
    @(posedge core_clk_i);
    hib <= 1'b1;
    @(posedge core_clk_i);
    hib <= 1'b0;
    bus(1'b0, 8'h18, 32'h0);
    chk("hibernate clears", q, 32'h1);
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", q, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
